//--- core/rpa_pkg.sv
// package for the ram port with dma arbiter: address map, sizes, channel order, bus types
// assumes one system clock domain and word-wide storage in flip-flops
package rpa_pkg;

    localparam logic [31:0] RAM_BASE = 32'h2000_0000;
    localparam int RAM_BYTES = 8192;
    localparam int WORD_BYTES = 4;
    localparam int RAM_WORDS = RAM_BYTES / WORD_BYTES;
    localparam int IDX_W = 11;
    localparam int DMA_CH = 6;
    localparam int FAST_WAIT = 2;
    localparam logic [1:0] FAST_WAIT_CNT = 2'h2;
    // address bits above the ram window
    localparam int DEC_LSB = 13;

    // channel index doubles as priority, 0 highest
    localparam logic [2:0] CH_ADC = 3'h0;
    localparam logic [2:0] CH_SC2_RX = 3'h1;
    localparam logic [2:0] CH_SC2_TX = 3'h2;
    localparam logic [2:0] CH_MAC = 3'h3;
    localparam logic [2:0] CH_SC1_RX = 3'h4;
    localparam logic [2:0] CH_SC1_TX = 3'h5;

    // access size
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;

    // master ids on the grant output
    localparam logic [3:0] M_NONE = 4'h0;
    localparam logic [3:0] M_CPU = 4'h1;
    localparam logic [3:0] M_DBG = 4'h2;
    localparam logic [3:0] M_DMA0 = 4'h8;

    typedef struct packed {
        logic req;
        logic wr;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } rpa_req_t;

    typedef struct packed {
        logic done;
        logic err;
        logic [31:0] rdata;
    } rpa_rsp_t;

    typedef enum logic [1:0] {
        RPA_IDLE,
        RPA_WAIT,
        RPA_DONE
    } rpa_state_t;

endpackage : rpa_pkg

//--- core/rpa_ram_port.sv
// ram port: 8 kbyte static ram with an arbiter in front of it: fixed dma priority, processor slot after each dma access
// assumes masters hold a request stable until done, all inputs synchronous to clk_i
// ram contents are not cleared by reset; only control state and answers are
`timescale 1ns/100ps
`default_nettype none

module rpa_ram_port
    import rpa_pkg::*;
(
    input wire logic clk_i, // system clock
    input wire logic sys_rst_i, // sync reset, active high
    input wire logic fast_mode_i, // cpu in higher clock mode
    input wire rpa_req_t cpu_req_i, // processor request
    input wire rpa_req_t dbg_req_i, // debugger request
    input wire rpa_req_t [DMA_CH-1:0] dma_req_i, // dma requests, index is priority
    output rpa_rsp_t cpu_rsp_o, // processor answer
    output rpa_rsp_t dbg_rsp_o, // debugger answer
    output rpa_rsp_t [DMA_CH-1:0] dma_rsp_o, // dma answers
    output logic [3:0] grant_o // master holding the ram
);

    ////////////////////////////////////////////////////////////////////////
    // storage and state
    logic [31:0] mem [RAM_WORDS];
    rpa_state_t state, next_state;
    logic [1:0] wcnt, next_wcnt;
    logic [3:0] owner, next_owner;
    // the taken request is latched, so the access runs on what was granted
    rpa_req_t cur, next_cur;
    rpa_rsp_t cpu_rsp, dbg_rsp;
    rpa_rsp_t [DMA_CH-1:0] dma_rsp;
    rpa_rsp_t next_rsp;
    logic cpu_turn, next_cpu_turn;

    ////////////////////////////////////////////////////////////////////////
    // arbitration
    logic [3:0] pick;
    rpa_req_t pick_req;
    logic any_dma;

    always_comb begin
        pick = M_NONE;
        pick_req = '0;
        any_dma = 1'b0;
        // scan from the top index down so the lowest requesting index is written last
        for (int i = DMA_CH - 1; i >= 0; i--) begin
            if (dma_req_i[i].req) begin
                any_dma = 1'b1;
                pick = M_DMA0 + 4'(i);
                pick_req = dma_req_i[i];
            end
        end
        // after each dma access the processor gets a slot if it waits
        // the debugger only takes idle slots; it is never time critical
        if (cpu_req_i.req && (!any_dma || cpu_turn)) begin
            pick = M_CPU;
            pick_req = cpu_req_i;
        end else if (!any_dma && dbg_req_i.req) begin
            pick = M_DBG;
            pick_req = dbg_req_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // access sequencing
    logic hit;
    logic [IDX_W-1:0] idx;
    logic [3:0] lanes;
    logic [31:0] wword;

    always_comb begin
        // word accesses ignore addr[1:0]; half-words use addr[1] only
        hit = (cur.addr[31:DEC_LSB] == RAM_BASE[31:DEC_LSB]);
        idx = cur.addr[DEC_LSB-1:2];
        unique case (cur.size)
            SZ_BYTE: lanes = 4'h1 << cur.addr[1:0];
            SZ_HALF: lanes = cur.addr[1] ? 4'hc : 4'h3;
            default: lanes = 4'hf;
        endcase
        // narrow data arrives on its own lanes, little-endian
        wword = mem[idx];
        for (int b = 0; b < WORD_BYTES; b++) begin
            if (lanes[b]) begin
                wword[b*8 +: 8] = cur.wdata[b*8 +: 8];
            end
        end
    end

    always_comb begin
        next_state = state;
        next_wcnt = wcnt;
        next_owner = owner;
        next_cur = cur;
        next_cpu_turn = cpu_turn;
        next_rsp = '0;
        unique case (state)
            RPA_IDLE: begin
                if (pick != M_NONE) begin
                    next_owner = pick;
                    next_cur = pick_req;
                    next_wcnt = fast_mode_i ? FAST_WAIT_CNT : 2'h0;
                    next_state = RPA_WAIT;
                    // a dma access hands the next slot to the processor, so a busy channel
                    next_cpu_turn = (pick != M_CPU) && (pick != M_DBG); // cannot lock it out
                end
            end
            RPA_WAIT: begin
                if (wcnt == 2'h0) begin
                    next_rsp.done = 1'b1;
                    next_rsp.err = !hit;
                    next_rsp.rdata = hit ? mem[idx] : 32'h0;
                    next_state = RPA_DONE;
                end else begin
                    next_wcnt = wcnt - 2'h1;
                end
            end
            RPA_DONE: begin
                // one idle turn lets the master drop its request before rearbitration
                next_owner = M_NONE;
                next_state = RPA_IDLE;
            end
            default: begin
                // unused state code: drop any owner and go back to idle
                next_owner = M_NONE;
                next_state = RPA_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state <= RPA_IDLE;
            wcnt <= 2'h0;
            owner <= M_NONE;
            cur <= '0;
            cpu_turn <= 1'b0;
        end else begin
            state <= next_state;
            wcnt <= next_wcnt;
            owner <= next_owner;
            cur <= next_cur;
            cpu_turn <= next_cpu_turn;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // answer routing
    rpa_rsp_t next_cpu_rsp, next_dbg_rsp;
    rpa_rsp_t [DMA_CH-1:0] next_dma_rsp;

    // only the owner sees done; the others keep waiting with their requests held
    always_comb begin
        next_cpu_rsp = '0;
        next_dbg_rsp = '0;
        next_dma_rsp = '0;
        if (owner == M_CPU) begin
            next_cpu_rsp = next_rsp;
        end
        if (owner == M_DBG) begin
            next_dbg_rsp = next_rsp;
        end
        // serial rx and tx answer on separate channels, so both directions complete
        for (int i = 0; i < DMA_CH; i++) begin
            if (owner == M_DMA0 + 4'(i)) begin
                next_dma_rsp[i] = next_rsp;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cpu_rsp <= '0;
            dbg_rsp <= '0;
            dma_rsp <= '0;
        end else begin
            cpu_rsp <= next_cpu_rsp;
            dbg_rsp <= next_dbg_rsp;
            dma_rsp <= next_dma_rsp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // storage write
    logic mem_we;

    // the write lands on the edge that raises done; a miss never touches the array
    always_comb begin
        mem_we = (state == RPA_WAIT) && (wcnt == 2'h0) && hit && cur.wr;
    end

    // no reset on the array itself: contents are undefined after power-up,
    // and reset only gates the write enable of the array, so no word is ever cleared
    always_ff @(posedge clk_i) begin
        if (!sys_rst_i && mem_we) begin
            mem[idx] <= wword;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, each straight from a register
    assign cpu_rsp_o = cpu_rsp;
    assign dbg_rsp_o = dbg_rsp;
    assign dma_rsp_o = dma_rsp;
    assign grant_o = owner;

endmodule // rpa_ram_port

`default_nettype wire

//--- tb/rpa_master_model.sv
// bus master model: holds a request from load until its answer, then releases
// assumes load_i and cmd_i change at the falling clock edge
`timescale 1ns/100ps
`default_nettype none
module rpa_master_model
    import rpa_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic load_i, // issue cmd_i
    input wire rpa_req_t cmd_i, // request
    input wire rpa_rsp_t rsp_i, // answer
    output rpa_req_t req_o = '0 // held request
);
    always @(posedge clk_i) begin
        if (load_i) begin
            req_o <= cmd_i;
        end else if (rsp_i.done) begin
            // released lines must not show stale values
            req_o <= {1'b0, ~req_o.wr, ~req_o.size, ~req_o.addr, ~req_o.wdata};
        end
    end
endmodule // rpa_master_model
`default_nettype wire

//--- tb/rpa_ram_port_sva.sv
// checker for the ram port arbiter
// assumes the bench holds requests until done
`timescale 1ns/100ps
`default_nettype none
module rpa_ram_port_sva
    import rpa_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic sys_rst_i, // reset
    input wire logic fast_mode_i, // fast mode
    input wire rpa_req_t cpu_req_i, // cpu req
    input wire rpa_req_t [DMA_CH-1:0] dma_req_i, // dma req
    input wire rpa_rsp_t cpu_rsp_o, // cpu rsp
    input wire rpa_rsp_t dbg_rsp_o, // dbg rsp
    input wire rpa_rsp_t [DMA_CH-1:0] dma_rsp_o, // dma rsp
    input wire logic [3:0] grant_o // owner
);
    logic [DMA_CH-1:0] rq;
    logic [DMA_CH-1:0] dn;
    always_comb begin
        for (int i = 0; i < DMA_CH; i++) begin
            rq[i] = dma_req_i[i].req;
            dn[i] = dma_rsp_o[i].done;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_fast_done;
        ##1 !cpu_rsp_o.done [*2] ##1 cpu_rsp_o.done;
    endsequence
    ////////////////////////////////////////////////////////////////
    AST_ONE_DONE: assert property ($onehot0({dn, cpu_rsp_o.done, dbg_rsp_o.done}))
        else $error("two answers");
    AST_NORM: assert property ($changed(grant_o) && grant_o == M_CPU && !$past(fast_mode_i)
        |-> ##1 cpu_rsp_o.done) else $error("normal latency");
    AST_FAST: assert property ($changed(grant_o) && grant_o == M_CPU && $past(fast_mode_i)
        |-> s_fast_done) else $error("fast latency");
    AST_PRIO: assert property ($changed(grant_o) && grant_o[3]
        |-> ($past(rq) & ((6'h1 << grant_o[2:0]) - 6'h1)) == 6'h0) else $error("dma order");
    AST_CPU_TURN: assert property ($fell(grant_o[3]) && cpu_req_i.req |=> grant_o == M_CPU)
        else $error("cpu starved");
    AST_DBG: assert property ($changed(grant_o) && grant_o == M_DBG
        |-> $past(rq) == 6'h0 && !$past(cpu_req_i.req)) else $error("dbg early");
    AST_HOLD: assert property (cpu_rsp_o.done |-> grant_o == M_CPU ##1 grant_o == M_NONE)
        else $error("grant hold");
    AST_ERR: assert property (cpu_rsp_o.done |-> cpu_rsp_o.err ==
        (cpu_req_i.addr[31:DEC_LSB] != RAM_BASE[31:DEC_LSB])) else $error("decode");
endmodule // rpa_ram_port_sva
bind rpa_ram_port rpa_ram_port_sva u_sva (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .fast_mode_i(fast_mode_i), .cpu_req_i(cpu_req_i), .dma_req_i(dma_req_i),
    .cpu_rsp_o(cpu_rsp_o), .dbg_rsp_o(dbg_rsp_o), .dma_rsp_o(dma_rsp_o), .grant_o(grant_o));
`default_nettype wire

//--- tb/test_ram_port_with_dma_arbiter.sv
// bench: masters 0..5 dma, 6 cpu, 7 debugger, memory model in an assoc array
// assumes each master model holds its request until the design answers it
`timescale 1ns/100ps
`default_nettype none
module test_ram_port_with_dma_arbiter;
    import rpa_pkg::*;
    logic clk_i = 0, sys_rst_i = 1, fast_mode_i = 0;
    logic [7:0] ld = 0;
    rpa_req_t [7:0] cmd = '0;
    wire rpa_req_t [7:0] req;
    wire rpa_rsp_t [7:0] rsp;
    logic [3:0] grant_o, last = 0, got[$];
    logic [3:0] exp_q[8] = '{4'h8, 4'h1, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'h2};
    logic [31:0] seed = 32'h4d, a, mem[int];
    logic [1:0] s;
    int mismatches = 0, samples_checked = 0;
    for (genvar g = 0; g < 8; g++) begin : g_master
        rpa_master_model u_m (.clk_i(clk_i), .load_i(ld[g]), .cmd_i(cmd[g]), .rsp_i(rsp[g]),
            .req_o(req[g]));
    end
    rpa_ram_port i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .fast_mode_i(fast_mode_i),
        .cpu_req_i(req[6]), .dbg_req_i(req[7]), .dma_req_i(req[5:0]), .cpu_rsp_o(rsp[6]),
        .dbg_rsp_o(rsp[7]), .dma_rsp_o(rsp[5:0]), .grant_o(grant_o));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [33:0] g, e);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic op(input int m, input logic wr, input logic [1:0] sz, input logic [31:0] a, d);
        int w;
        logic oor;
        w = int'(a[12:2]);
        oor = a[31:DEC_LSB] != RAM_BASE[31:DEC_LSB];
        @(negedge clk_i);
        fast_mode_i = ^rnd();
        cmd[m] = '{1'b1, wr, sz, a, d};
        ld[m] = 1'b1;
        @(negedge clk_i);
        ld[m] = 1'b0;
        repeat (12) begin
            @(posedge clk_i);
            #1;
            if (rsp[m].done === 1'b1) break;
        end
        chk({rsp[m].done, rsp[m].err, wr ? 32'h0 : rsp[m].rdata}, {1'b1, oor, (wr || oor) ? 32'h0 : mem[w]});
        for (int b = 0; b < 4; b++) begin
            if (wr && !oor && (sz == SZ_WORD || b[1] == a[1] && (sz == SZ_HALF || b[0] == a[0]))) begin
                mem[w][8*b +: 8] = d[8*b +: 8];
            end
        end
    endtask
    task automatic complete_run();
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial forever #2.5 clk_i = ~clk_i;
    initial begin
        #40000;
        mismatches++;
        complete_run();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        @(negedge clk_i) sys_rst_i = 1'b0;
        for (int i = 0; i < 16; i++) op(6, 1, SZ_WORD, RAM_BASE + 4 * i, rnd());
        op(6, 1, SZ_WORD, RAM_BASE + 32'h1ffc, rnd());
        op(7, 0, SZ_BYTE, RAM_BASE + 32'h1fff, 0);
        op(6, 1, SZ_WORD, RAM_BASE + 32'h2000, rnd());
        for (int i = 0; i < 64; i++) begin
            s = 2'(rnd() % 3);
            a = RAM_BASE + (rnd() & 32'h3f);
            op(rnd() % 2 == 0 ? 6 : 7, ^rnd(), s, a & ~((32'h1 << s) - 32'h1), rnd());
        end
        @(negedge clk_i);
        fast_mode_i = 1'b0;
        for (int i = 0; i < 8; i++) cmd[i] = '{1'b1, 1'b0, SZ_WORD, RAM_BASE + 4 * i, 32'h0};
        ld = 8'hff;
        @(negedge clk_i);
        ld = 8'h00;
        repeat (40) begin
            @(posedge clk_i);
            #1;
            if (grant_o !== last && grant_o !== M_NONE) got.push_back(grant_o);
            last = grant_o;
            for (int i = 0; i < 8; i++) if (rsp[i].done === 1'b1) chk(rsp[i].rdata, mem[i]);
        end
        foreach (exp_q[i]) chk(got[i], exp_q[i]);
        complete_run();
    end
endmodule // test_ram_port_with_dma_arbiter
`default_nettype wire
